// file: design/usart_ctrl_pkg.sv
// Purpose: constants, field layouts and mode types for the serial port control block
// Assumes: APB register bus with 32-bit data; byte address is four times the register index
// Notes: shared by the control block and its testbench
//
// Behaviour
// - receiver runs only while receive enable set
// - transmitter runs only while transmit enable set
// - frame start detection follows its control bit
// - open-drain output drive when bit set
// - receiver speed field: normal, double, autobaud, LIN
// - multiprocessor addressing follows bit zero
// - communication mode: async, sync, infrared, host SPI
// - host SPI mode swaps frame register layout
// - frame register resets to 0x03
// - parity field: none, even, odd; one reserved
// - transmitter sends one or two stop bits
// - receiver ignores stop bit setting
// - shared character size five to nine bits
// - nine-bit byte order selects first byte
// - host SPI bit order MSB or LSB first
// - host SPI samples leading or trailing edge
`default_nettype none

package usart_ctrl_pkg;

    localparam int APB_DATA_W = 32;
    localparam int APB_ADDR_W = 8;
    localparam int REG_IDX_W = 6;
    localparam int IDX_LSB = 2;
    localparam int CHAR_W = 9;
    localparam int BYTE_W = 8;
    localparam int BITS_W = 4;

    // ======================================================================
    // register indices
    localparam logic [REG_IDX_W-1:0] IDX_RX_LOW = 6'h00;
    localparam logic [REG_IDX_W-1:0] IDX_RX_HIGH = 6'h01;
    localparam logic [REG_IDX_W-1:0] IDX_TX_LOW = 6'h02;
    localparam logic [REG_IDX_W-1:0] IDX_TX_HIGH = 6'h03;
    localparam logic [REG_IDX_W-1:0] IDX_STATUS = 6'h04;
    localparam logic [REG_IDX_W-1:0] IDX_RXTX_CTRL = 6'h06;
    localparam logic [REG_IDX_W-1:0] IDX_FRAME_CTRL = 6'h07;

    // ======================================================================
    // receive/transmit control fields
    localparam int BIT_RX_ON = 7;
    localparam int BIT_TX_ON = 6;
    localparam int BIT_FRAME_START = 4;
    localparam int BIT_OPEN_DRAIN = 3;
    localparam int FLD_RX_SPEED_LSB = 1;
    localparam int BIT_MULTIPROC = 0;

    // frame format fields, normal and host SPI layouts
    localparam int FLD_COMM_LSB = 6;
    localparam int FLD_PARITY_LSB = 4;
    localparam int BIT_STOP = 3;
    localparam int FLD_CHARACTER_SIZE_LSB = 0;
    localparam int BIT_SPI_ORDER = 2;
    localparam int BIT_SPI_PHASE = 1;

    // status fields
    localparam int BIT_ST_RX_AVAIL = 7;
    localparam int BIT_ST_TX_FREE = 5;
    localparam int BIT_ST_HIGH_STAGED = 0;

    // ======================================================================
    // reset values
    localparam logic [1:0] FIELD2_RESET = 2'h0;
    localparam logic [2:0] CHARACTER_SIZE_RESET = 3'h3;
    localparam logic [APB_DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

    // ======================================================================
    // mode types
    typedef enum logic [1:0] {COMM_ASYNC, COMM_SYNC, COMM_INFRARED, COMM_HOST_SPI} comm_mode_e;
    typedef enum logic [1:0] {RX_NORMAL, RX_DOUBLE, RX_GENERIC_AUTO, RX_LIN_AUTO} rx_speed_e;
    typedef enum logic [1:0] {PAR_NONE, PAR_RESERVED, PAR_EVEN, PAR_ODD} parity_e;

    // character size codes
    localparam logic [2:0] CHARACTER_SIZE_5 = 3'h0;
    localparam logic [2:0] CHARACTER_SIZE_6 = 3'h1;
    localparam logic [2:0] CHARACTER_SIZE_7 = 3'h2;
    localparam logic [2:0] CHARACTER_SIZE_8 = 3'h3;
    localparam logic [2:0] CHARACTER_SIZE_9_LOW = 3'h6;
    localparam logic [2:0] CHARACTER_SIZE_9_HIGH = 3'h7;

    // data bits per character; reserved codes fall back to eight
    function automatic logic [BITS_W-1:0] char_bits(input logic [2:0] code);
        logic [BITS_W-1:0] n;
        n = 4'h8;
        if (code == CHARACTER_SIZE_5) n = 4'h5;
        if (code == CHARACTER_SIZE_6) n = 4'h6;
        if (code == CHARACTER_SIZE_7) n = 4'h7;
        if (code == CHARACTER_SIZE_9_LOW || code == CHARACTER_SIZE_9_HIGH) n = 4'h9;
        return n;
    endfunction

endpackage

`default_nettype wire

// file: design/two_entry_buffer.sv
// Purpose: two-word buffer with valid/ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes: full and empty are exact; a stalled drain side fills it
`default_nettype none

module two_entry_buffer #(
    parameter int WIDTH = 9
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] slot [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;

    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    // ======================================================================
    // handshake flags from occupancy
    assign in_ready = (count != 2'd2);
    assign out_valid = (count != 2'd0);
    assign out_data = slot[rd_ptr];

    // pointer and count update
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'd0;
        end else begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
            if (push && !pop) count <= count + 2'd1;
            if (pop && !push) count <= count - 2'd1;
        end
    end

    // storage, no reset needed
    always_ff @(posedge pclk) begin
        if (push) slot[wr_ptr] <= in_data;
    end

endmodule

`default_nettype wire

// file: design/usart_mode_frame_control.sv
// Purpose: mode and frame control registers of a serial port, with data staging
// Assumes: APB slave, zero wait states; shifters sit outside and use the stream ports
// Notes: transmit words pass a two-entry buffer; receive holds one word
//
// The APB register port is this design's own decision.
`default_nettype none

module usart_mode_frame_control
    import usart_ctrl_pkg::*;
#(
    parameter int DATA_WIDTH = CHAR_W
) (
    input wire logic pclk,
    input wire logic presetn,

    // apb slave
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [APB_DATA_W-1:0] prdata,
    output logic pslverr,

    // decoded configuration
    output logic receiver_on,
    output logic transmitter_on,
    output logic frame_start_detect_on,
    output logic open_drain_select,
    output logic multiprocessor_addressing,
    output logic double_speed,
    output logic generic_autobaud,
    output logic lin_constrained_autobaud,
    output logic async_mode,
    output logic sync_mode,
    output logic infrared_mode,
    output logic host_spi_mode,
    output logic parity_enable,
    output logic parity_odd,
    output logic tx_two_stop_bits,
    output logic [BITS_W-1:0] data_bits,
    output logic nine_bit_low_first,
    output logic nine_bit_high_first,
    output logic spi_lsb_first,
    output logic spi_sample_trailing,

    // transmit stream to the shifter
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [DATA_WIDTH-1:0] tx_data,

    // receive stream from the shifter
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [DATA_WIDTH-1:0] rx_data,

    // serial output pin
    input wire logic shifter_txd,
    output logic txd_out,
    output logic txd_oe_n
);

    // ======================================================================
    // control register state
    logic rx_on_q;
    logic tx_on_q;
    logic frame_start_q;
    logic open_drain_q;
    logic multiproc_q;
    rx_speed_e rx_speed;
    comm_mode_e comm_mode;
    parity_e parity_select;
    logic stop_bit_count;
    logic [2:0] character_size;
    logic spi_bit_order;
    logic spi_clock_phase;

    // data staging state
    logic [BYTE_W-1:0] tx_low_staged;
    logic tx_high_staged;
    logic [DATA_WIDTH-1:0] rx_hold;
    logic rx_avail;

    // ======================================================================
    // apb decode
    wire [REG_IDX_W-1:0] reg_index = paddr[IDX_LSB +: REG_IDX_W];
    wire index_known = (reg_index == IDX_RX_LOW) || (reg_index == IDX_RX_HIGH) ||
                       (reg_index == IDX_TX_LOW) || (reg_index == IDX_TX_HIGH) ||
                       (reg_index == IDX_STATUS) || (reg_index == IDX_RXTX_CTRL) ||
                       (reg_index == IDX_FRAME_CTRL);

    // phases of the current transfer
    wire apb_setup = psel & ~penable;
    wire apb_access = psel & penable;
    wire wr_en = apb_access & pwrite & index_known & pstrb[0];
    wire rd_en = apb_access & ~pwrite & index_known;

    // zero wait states; unmapped address answers with an error
    assign pready = 1'b1;
    assign pslverr = apb_access & ~index_known;

    // per-register write strobes
    // a write without lane 0 changes nothing
    wire wr_rxtx_ctrl = wr_en & (reg_index == IDX_RXTX_CTRL);
    wire wr_frame_ctrl = wr_en & (reg_index == IDX_FRAME_CTRL);
    wire wr_tx_low = wr_en & (reg_index == IDX_TX_LOW);
    wire wr_tx_high = wr_en & (reg_index == IDX_TX_HIGH);

    // ======================================================================
    // mode decoding
    wire nine_low = (character_size == CHARACTER_SIZE_9_LOW);
    wire nine_high = (character_size == CHARACTER_SIZE_9_HIGH);
    wire spi_now = (comm_mode == COMM_HOST_SPI);
    // layout follows the mode being written
    wire [1:0] new_comm = pwdata[FLD_COMM_LSB +: 2];
    wire new_is_spi = (comm_mode_e'(new_comm) == COMM_HOST_SPI);

    // byte that completes a nine-bit word on each side
    wire [REG_IDX_W-1:0] tx_push_index = nine_low ? IDX_TX_HIGH : IDX_TX_LOW;
    wire [REG_IDX_W-1:0] rx_pop_index = nine_low ? IDX_RX_HIGH : IDX_RX_LOW;

    // keeps only the bits of the configured character size
    function automatic logic [DATA_WIDTH-1:0] char_mask(input logic [BITS_W-1:0] n);
        logic [DATA_WIDTH-1:0] m;
        m = '0;
        for (int i = 0; i < DATA_WIDTH; i++) begin
            if (i < int'(n)) m[i] = 1'b1;
        end
        return m;
    endfunction

    // frame register read view follows the current mode
    function automatic logic [BYTE_W-1:0] frame_view();
        logic [BYTE_W-1:0] v;
        v = '0;
        v[FLD_COMM_LSB +: 2] = comm_mode;
        if (comm_mode == COMM_HOST_SPI) begin
            v[BIT_SPI_ORDER] = spi_bit_order;
            v[BIT_SPI_PHASE] = spi_clock_phase;
        end else begin
            v[FLD_PARITY_LSB +: 2] = parity_select;
            v[BIT_STOP] = stop_bit_count;
            v[FLD_CHARACTER_SIZE_LSB +: 3] = character_size;
        end
        return v;
    endfunction

    // receive/transmit control read view
    function automatic logic [BYTE_W-1:0] rxtx_view();
        logic [BYTE_W-1:0] v;
        v = '0;
        v[BIT_RX_ON] = rx_on_q;
        v[BIT_TX_ON] = tx_on_q;
        v[BIT_FRAME_START] = frame_start_q;
        v[BIT_OPEN_DRAIN] = open_drain_q;
        v[FLD_RX_SPEED_LSB +: 2] = rx_speed;
        v[BIT_MULTIPROC] = multiproc_q;
        return v;
    endfunction

    // ======================================================================
    // receive/transmit control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_on_q <= 1'b0;
            tx_on_q <= 1'b0;
            frame_start_q <= 1'b0;
            open_drain_q <= 1'b0;
            rx_speed <= rx_speed_e'(FIELD2_RESET);
            multiproc_q <= 1'b0;
        end else if (wr_rxtx_ctrl) begin
            rx_on_q <= pwdata[BIT_RX_ON];
            tx_on_q <= pwdata[BIT_TX_ON];
            frame_start_q <= pwdata[BIT_FRAME_START];
            open_drain_q <= pwdata[BIT_OPEN_DRAIN];
            rx_speed <= rx_speed_e'(pwdata[FLD_RX_SPEED_LSB +: 2]);
            multiproc_q <= pwdata[BIT_MULTIPROC];
        end
    end

    // ======================================================================
    // frame format register; the written mode picks the layout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comm_mode <= comm_mode_e'(FIELD2_RESET);
            parity_select <= parity_e'(FIELD2_RESET);
            stop_bit_count <= 1'b0;
            character_size <= CHARACTER_SIZE_RESET;
            spi_bit_order <= 1'b0;
            spi_clock_phase <= 1'b0;
        end else if (wr_frame_ctrl) begin
            comm_mode <= comm_mode_e'(new_comm);
            if (new_is_spi) begin
                spi_bit_order <= pwdata[BIT_SPI_ORDER];
                spi_clock_phase <= pwdata[BIT_SPI_PHASE];
            end else begin
                parity_select <= parity_e'(pwdata[FLD_PARITY_LSB +: 2]);
                stop_bit_count <= pwdata[BIT_STOP];
                character_size <= pwdata[FLD_CHARACTER_SIZE_LSB +: 3];
            end
        end
    end

    // ======================================================================
    // configuration outputs
    assign receiver_on = rx_on_q;
    assign transmitter_on = tx_on_q;
    assign frame_start_detect_on = frame_start_q;
    assign open_drain_select = open_drain_q;
    assign multiprocessor_addressing = multiproc_q;

    // speed decode; async and infrared rely on software keeping it normal
    assign double_speed = (rx_speed == RX_DOUBLE);
    assign generic_autobaud = (rx_speed == RX_GENERIC_AUTO);
    assign lin_constrained_autobaud = (rx_speed == RX_LIN_AUTO);

    // communication mode decode
    assign async_mode = (comm_mode == COMM_ASYNC);
    assign sync_mode = (comm_mode == COMM_SYNC);
    assign infrared_mode = (comm_mode == COMM_INFRARED);
    assign host_spi_mode = spi_now;

    // parity decode; the reserved code behaves as no parity
    assign parity_enable = ~spi_now &
                           ((parity_select == PAR_EVEN) || (parity_select == PAR_ODD));
    assign parity_odd = ~spi_now & (parity_select == PAR_ODD);

    // stop count goes to the transmitter only, the receiver never sees it
    assign tx_two_stop_bits = ~spi_now & stop_bit_count;

    // one character size for both directions
    assign data_bits = spi_now ? BITS_W'(BYTE_W) : char_bits(character_size);
    assign nine_bit_low_first = ~spi_now & nine_low;
    assign nine_bit_high_first = ~spi_now & nine_high;

    // host spi bit order and sampling edge; order must stay put mid-transfer
    assign spi_lsb_first = spi_now & spi_bit_order;
    assign spi_sample_trailing = spi_now & spi_clock_phase;

    // ======================================================================
    // transmit staging: the first byte waits, the completing byte pushes
    wire tx_push_write = (wr_tx_low && (tx_push_index == IDX_TX_LOW)) ||
                         (wr_tx_high && (tx_push_index == IDX_TX_HIGH));
    wire [DATA_WIDTH-1:0] tx_word_raw = nine_low ?
                         {pwdata[0], tx_low_staged} :
                         {tx_high_staged, pwdata[BYTE_W-1:0]};
    wire [DATA_WIDTH-1:0] tx_word = tx_word_raw & char_mask(data_bits);
    wire buf_in_ready;
    wire buf_out_valid;
    wire buf_out_ready = tx_ready & tx_on_q;

    // staged byte registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_low_staged <= '0;
            tx_high_staged <= 1'b0;
        end else begin
            if (wr_tx_low) tx_low_staged <= pwdata[BYTE_W-1:0];
            if (wr_tx_high) tx_high_staged <= pwdata[0];
        end
    end

    // transmit words buffered two deep for a stalled shifter; a completing write while both are full is dropped
    two_entry_buffer #(
        .WIDTH(DATA_WIDTH)
    ) tx_buffer (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(tx_push_write),
        .in_ready(buf_in_ready),
        .in_data(tx_word),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(tx_data)
    );

    // transmitter off holds words back
    assign tx_valid = buf_out_valid & tx_on_q;

    // ======================================================================
    // receive holding word; a new word wins over a pop in the same cycle
    wire rx_take = rx_valid & rx_ready;
    wire rx_pop = rd_en & (reg_index == rx_pop_index);
    assign rx_ready = rx_on_q & ~rx_avail;

    // receive capture and flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_hold <= '0;
            rx_avail <= 1'b0;
        end else begin
            if (rx_take) rx_hold <= rx_data & char_mask(data_bits);
            if (!rx_on_q) rx_avail <= 1'b0;
            else if (rx_take) rx_avail <= 1'b1;
            else if (rx_pop) rx_avail <= 1'b0;
        end
    end

    // ======================================================================
    // read data mux, registered in the setup phase
    logic [BYTE_W-1:0] status_view;
    logic [BYTE_W-1:0] read_byte;

    always_comb begin
        status_view = '0;
        status_view[BIT_ST_RX_AVAIL] = rx_avail;
        status_view[BIT_ST_TX_FREE] = buf_in_ready;
        status_view[BIT_ST_HIGH_STAGED] = tx_high_staged;

        read_byte = '0;
        if (reg_index == IDX_RX_LOW) read_byte = rx_hold[BYTE_W-1:0];
        if (reg_index == IDX_RX_HIGH) read_byte = {7'h00, rx_hold[BYTE_W]};
        if (reg_index == IDX_STATUS) read_byte = status_view;
        if (reg_index == IDX_RXTX_CTRL) read_byte = rxtx_view();
        if (reg_index == IDX_FRAME_CTRL) read_byte = frame_view();
    end

    // prdata flop
    // loaded in setup, so it stands through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= RDATA_ZERO;
        else if (apb_setup && !pwrite) prdata <= {24'h00_0000, read_byte};
    end

    // ======================================================================
    // serial pin drive: open drain only pulls low, released when off
    wire next_txd_out = open_drain_q ? 1'b0 : shifter_txd;
    wire next_txd_oe_n = ~tx_on_q | (open_drain_q & shifter_txd);

    // pin flops
    // reset leaves the pin released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_out <= 1'b1;
            txd_oe_n <= 1'b1;
        end else begin
            txd_out <= next_txd_out;
            txd_oe_n <= next_txd_oe_n;
        end
    end

endmodule

`default_nettype wire

// file: verif/usart_ctrl_props.sv
// Purpose: concurrent checks on the serial control block ports
// Assumes: single clock domain, asynchronous active-low reset
// Notes: bound to every instance of the block
`default_nettype none

module usart_ctrl_props
    import usart_ctrl_pkg::*;
#(
    parameter int DATA_WIDTH = CHAR_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic receiver_on,
    input wire logic transmitter_on,
    input wire logic open_drain_select,
    input wire logic double_speed,
    input wire logic generic_autobaud,
    input wire logic lin_constrained_autobaud,
    input wire logic host_spi_mode,
    input wire logic spi_lsb_first,
    input wire logic spi_sample_trailing,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [DATA_WIDTH-1:0] tx_data,
    input wire logic rx_ready,
    input wire logic shifter_txd,
    input wire logic txd_out,
    input wire logic txd_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========
    // sequences: a completed control write, a stalled word
    sequence ctrl_write;
        psel && penable && pwrite && pstrb[0] && paddr == {IDX_RXTX_CTRL, 2'b00};
    endsequence
    sequence tx_stalled;
        tx_valid && !tx_ready ##1 transmitter_on;
    endsequence

    // ==========
    // enables, stream gating, pin drive, decodes
    chk_enable_write: assert property (ctrl_write |=>
        {receiver_on, transmitter_on} == $past(pwdata[7:6])) else $error("enable bits wrong");
    chk_rx_gated: assert property (!receiver_on |-> !rx_ready)
        else $error("rx ready while receiver off");
    chk_tx_gated: assert property (!transmitter_on |-> !tx_valid)
        else $error("tx valid while transmitter off");
    chk_tx_hold: assert property (tx_stalled |-> tx_valid && $stable(tx_data))
        else $error("stalled word lost");
    chk_open_drain: assert property (transmitter_on && open_drain_select |=>
        !txd_out && txd_oe_n == $past(shifter_txd)) else $error("open drain pin wrong");
    chk_push_pull: assert property (transmitter_on && !open_drain_select |=>
        !txd_oe_n && txd_out == $past(shifter_txd)) else $error("push pull pin wrong");
    chk_speed_decode: assert property (
        $onehot0({double_speed, generic_autobaud, lin_constrained_autobaud}))
        else $error("speed decode not exclusive");
    chk_spi_layout: assert property (!host_spi_mode |->
        !spi_lsb_first && !spi_sample_trailing) else $error("spi fields outside spi mode");
endmodule

bind usart_mode_frame_control usart_ctrl_props #(.DATA_WIDTH(DATA_WIDTH)) u_props(.*);

`default_nettype wire

// file: verif/shifter_model.sv
// Purpose: stand-in for the serial shifters on the far side of the streams
// Assumes: controlled by the bench through stall and rx_go
// Notes: rx data shows inverted garbage while no word is offered
`default_nettype none

module shifter_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic rx_go,
    input wire logic [8:0] rx_word,
    output logic tx_ready,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [8:0] rx_data,
    output logic shifter_txd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] last;

    // ==========
    // transmit side takes words unless stalled
    assign tx_ready = !stall;
    assign rx_data = rx_valid ? last : ~last;

    // offer one received word, serial bit toggles every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_valid <= 1'b0;
            last <= 9'h000;
            shifter_txd <= 1'b1;
        end else begin
            shifter_txd <= ~shifter_txd;
            if (rx_go) begin
                rx_valid <= 1'b1;
                last <= rx_word;
            end else if (rx_ready) begin
                rx_valid <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// file: verif/testbench.sv
// Purpose: register and stream tests of the serial control block
// Assumes: zero-wait apb slave; byte address is four times the index
// Notes: far side is the shifter model
`default_nettype none

module testbench
    import usart_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_ST = {IDX_STATUS, 2'b00};
    localparam logic [7:0] A_CB = {IDX_RXTX_CTRL, 2'b00};
    localparam logic [7:0] A_CC = {IDX_FRAME_CTRL, 2'b00};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, stall, rx_go;
    logic receiver_on, transmitter_on, frame_start_detect_on, open_drain_select;
    logic multiprocessor_addressing, double_speed, generic_autobaud, lin_constrained_autobaud;
    logic async_mode, sync_mode, infrared_mode, host_spi_mode, parity_enable, parity_odd;
    logic tx_two_stop_bits, nine_bit_low_first, nine_bit_high_first, spi_lsb_first;
    logic spi_sample_trailing, tx_valid, tx_ready, rx_valid, rx_ready, shifter_txd;
    logic txd_out, txd_oe_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb, data_bits;
    logic [8:0] tx_data, rx_data, rx_word;
    logic [8:0] got[$];
    int failures, n_compared, n;

    // ==========
    // design, far side, clock
    usart_mode_frame_control uut(.*);
    shifter_model far(.*);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (presetn === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_data);
    end

    // ==========
    // apb transfer, compare, wait for taken words, verdict
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        err = pslverr;
        if (k >= 20) failures++;
        psel <= 1'b0; penable <= 1'b0;
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic wait_got(input int k);
        for (int m = 0; m < 20 && got.size() < k; m++) @(posedge pclk);
    endtask
    task automatic wrap_up;
        $display("compared %0d failed %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #1_000_000;
        failures++;
        wrap_up;
    end

    // ==========
    // test sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rx_go, rx_word, failures, n_compared} = '0;
        pstrb = 4'h1; stall = 1'b1; presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, A_CC, 0); chk("frame reset", q, 32'h0000_0003);
        chk("async reset", async_mode, 1);
        apb(1, A_CB, 32'h0000_0099); chk("rx on", receiver_on, 1);
        chk("tx off", transmitter_on, 0);
        chk("frame start", frame_start_detect_on, 1);
        chk("open drain", open_drain_select, 1);
        chk("multiproc", multiprocessor_addressing, 1);
        apb(0, A_CB, 0); chk("ctrl read", q, 32'h0000_0099);
        apb(1, A_CC, 32'h0000_0043);
        for (int i = 0; i < 4; i++) begin
            apb(1, A_CB, i << 1);
            chk("speed", {lin_constrained_autobaud, generic_autobaud, double_speed}, (1 << i) >> 1);
        end
        apb(1, A_CB, 0);
        for (int i = 0; i < 4; i++) begin
            apb(1, A_CC, i * 64 + 11);
            chk("mode", {host_spi_mode, infrared_mode, sync_mode, async_mode}, 1 << i);
            chk("phase", spi_sample_trailing, i == 3);
            chk("stops", tx_two_stop_bits, i != 3);
        end
        apb(1, A_CC, 32'h0000_00c4); chk("lsb first", spi_lsb_first, 1);
        chk("leading", spi_sample_trailing, 0);
        apb(0, A_CC, 0); chk("spi view", q, 32'h0000_00c4);
        for (int i = 0; i < 4; i++) begin
            apb(1, A_CC, 3 + (i << 4)); chk("parity", parity_enable, i > 1);
            chk("odd", parity_odd, i == 3);
        end
        for (int i = 0; i < 8; i++) begin
            apb(1, A_CC, i); chk("bits", data_bits, i < 4 ? i + 5 : (i > 5 ? 9 : 8));
            chk("order", {nine_bit_high_first, nine_bit_low_first}, i > 5 ? i - 5 : 0);
        end
        apb(1, A_CB, 32'h0000_0040); apb(1, A_CC, 6); chk("push pull", txd_oe_n, 0);
        apb(1, 8, 32'h0000_00a5); apb(1, 12, 1);
        apb(1, 8, 32'h0000_003c); apb(1, 12, 0);
        apb(0, A_ST, 0); chk("buffer full", q[5], 0);
        apb(1, 8, 32'h0000_0077); apb(1, 12, 1);
        chk("held word", tx_data, 9'h1a5);
        @(posedge pclk) stall <= 1'b0;
        wait_got(2); chk("taken", got.size(), 2);
        chk("first", got[0], 9'h1a5); chk("second", got[1], 9'h03c);
        apb(1, A_CC, 7); apb(1, 12, 1); apb(1, 8, 32'h0000_005a);
        wait_got(3); chk("high first", got[$], 9'h15a);
        apb(1, A_CB, 32'h0000_0048);
        @(posedge pclk) #1 chk("od low", txd_out, 0);
        apb(1, A_CB, 32'h0000_0080); apb(1, A_CC, 32'h0000_000b);
        apb(1, 8, 5); chk("tx held", tx_valid, 0);
        @(posedge pclk) {rx_word, rx_go} <= {9'h1c3, 1'b1};
        @(posedge pclk) rx_go <= 1'b0;
        n = 0;
        do begin
            apb(0, A_ST, 0);
            n++;
        end while (q[7] !== 1'b1 && n < 10);
        apb(0, 0, 0); chk("rx word", q, 32'h0000_00c3);
        apb(1, A_CB, 0); chk("rx off", rx_ready, 0);
        apb(0, 8'h3c, 0); chk("unmapped", err, 1); chk("ready", pready, 1);
        wrap_up;
    end
endmodule

`default_nettype wire
